// file: aiac_top.sv
// Function
// - config bits 24..31 enable channels; disabled channels store nothing
// - clock initiator bit high: sample clocks from rate generator A or software bit
// - software sample clock bit yields one sample clock while burst is disabled or a burst is busy
// - clock initiator: 100 ns low pulse on clock pin per sample clock
// - clock target: pin is input, each falling edge is a sample clock
// - clock initiator bit resets low, so the board starts as target
// - burst disabled: sample continuously while a clock source exists
// - burst enabled: trigger starts burst of configured length per channel
// - zero burst length gives an endless burst until stopped
// - last word of each burst that reaches its configured length carries the end flag at bit 17
// - burst busy flag is high exactly during a triggered burst
// - triggers are ignored while burst ready is low
// - trigger initiator: triggers from rate generator B or software bit
// - trigger initiator: 100 ns low pin pulse per input or output trigger
// - trigger target: pin falling edge triggers inputs and outputs side
// - FIFO words: data 0..15, tag 16, end flag 17, zeros above
// - first channel tag marks lowest active channel of each set
// - FIFO accepts samples only while buffer enable is high
// - writing buffer clear empties the FIFO and self clears
// - reading an empty FIFO sets the underflow flag
// - sample arriving while the sequencer still holds a set sets the overflow flag
// - flags stay set until a control write with the flag bit low, buffer clear or reset
`timescale 1ns/10ps
`default_nettype none
`include "aiac_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module aiac_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule : aiac_fifo

////////////////////////////////////////////////////////////////////////////////
module aiac_top #(
  parameter int FIFO_DEPTH = `AIAC_FIFO_DEPTH
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire aiac_pkg::aiac_req_t HOST_REQ,
  output logic [31:0] RD_DATA,
  output logic RD_VALID,
  input wire aiac_pkg::aiac_adc_t ADC_SAMPLES,
  output logic ADC_CONVERT,
  input wire logic RATE_A_TICK,
  input wire logic RATE_B_TICK,
  input wire logic OUT_TRIG_IN,
  output logic TRIG_TO_OUTPUT,
  input wire logic CLK_PIN_IN,
  output logic CLK_PIN_OUT,
  output logic CLK_PIN_OE,
  input wire logic TRIG_PIN_IN,
  output logic TRIG_PIN_OUT,
  output logic TRIG_PIN_OE
);
  import aiac_pkg::*;

  localparam int NCH = `AIAC_CHANNELS;
  localparam logic [3:0] PULSE_CYC = 4'(`AIAC_PIN_PULSE_CYC);

  if (NCH != 8) begin : g_bad_nch
    $error("channel count is fixed at eight");
  end

  function automatic logic [2:0] lowest_idx(input logic [7:0] m);
    logic [2:0] r;
    r = 3'd0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) r = 3'(i);
    end
    return r;
  endfunction : lowest_idx

  function automatic logic [3:0] pulse_next(input logic [3:0] c, input logic ev);
    logic [3:0] n;
    n = (c != 4'h0) ? c - 4'h1 : 4'h0;
    if (ev) n = PULSE_CYC;
    return n;
  endfunction : pulse_next

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl_q;
  logic [31:0] cfg_q;
  logic ovf_q;
  logic unf_q;
  logic sw_clk_q;
  logic sw_trig_q;
  logic clr_q;
  logic [31:0] rd_data_q;
  logic rd_valid_q;
  aiac_burst_t state_q;
  aiac_burst_t state_d;

  wire wr_ctrl = HOST_REQ.wr && HOST_REQ.addr == `AIAC_OFS_CTRL;
  wire wr_cfg = HOST_REQ.wr && HOST_REQ.addr == `AIAC_OFS_CFG;
  wire rd_fifo = HOST_REQ.rd && HOST_REQ.addr == `AIAC_OFS_FIFO;

  wire burst_en = ctrl_q[`AIAC_B_BURST_EN];
  wire buf_en = ctrl_q[`AIAC_B_BUF_EN];
  wire clk_init = ctrl_q[`AIAC_B_CLK_INIT];
  wire trig_init = ctrl_q[`AIAC_B_TRIG_INIT];
  wire rate_a_en = ctrl_q[`AIAC_B_RATE_A_EN];
  wire rate_b_en = ctrl_q[`AIAC_B_RATE_B_EN];
  wire [23:0] burst_len = cfg_q[`AIAC_CFG_LEN_MSB:0];
  wire [7:0] chan_en = cfg_q[31:`AIAC_CFG_ENA_LSB];
  wire busy = state_q == AIAC_BURST;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and falling edge detect
  logic clk_s1_q;
  logic clk_s2_q;
  logic clk_s3_q;
  logic trg_s1_q;
  logic trg_s2_q;
  logic trg_s3_q;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      clk_s1_q <= 1'b1;
      clk_s2_q <= 1'b1;
      clk_s3_q <= 1'b1;
      trg_s1_q <= 1'b1;
      trg_s2_q <= 1'b1;
      trg_s3_q <= 1'b1;
    end else begin
      clk_s1_q <= CLK_PIN_IN;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      trg_s1_q <= TRIG_PIN_IN;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
    end
  end

  // the own pulse is seen on the pin too, so edges only count in target mode
  wire clk_fall = !clk_init && clk_s3_q && !clk_s2_q;
  wire trg_fall = !trig_init && trg_s3_q && !trg_s2_q;

  ////////////////////////////////////////////////////////////////////////////////
  // sample clock and trigger sources
  wire rate_a_clk = clk_init && rate_a_en && RATE_A_TICK;
  wire samp_clk = sw_clk_q || rate_a_clk || clk_fall;
  wire gen_clk = sw_clk_q || rate_a_clk;

  wire rate_b_trig = trig_init && rate_b_en && RATE_B_TICK;
  wire gen_trig = sw_trig_q || rate_b_trig;
  wire any_trig = gen_trig || trg_fall;
  wire burst_ready = burst_en && !busy;
  wire trig_take = any_trig && burst_ready;

  // a burst only runs while the clock pin is an input or rate generator A is enabled; the software bit alone does not keep it
  wire clk_present = clk_init ? rate_a_en : 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // burst control
  logic [23:0] cnt_q;
  logic endless_q;
  logic samp_take;
  logic last_set;

  assign samp_take = samp_clk && (!burst_en || busy);
  assign last_set = busy && !endless_q && (cnt_q + 24'h00_0001 >= burst_len);

  always_comb begin
    state_d = state_q;
    case (state_q)
      AIAC_IDLE: begin
        if (trig_take) state_d = AIAC_BURST;
      end
      AIAC_BURST: begin
        if (!burst_en || !clk_present) state_d = AIAC_IDLE;
        else if (endless_q && burst_len != 24'h00_0000) state_d = AIAC_IDLE;
        else if (samp_take && last_set) state_d = AIAC_IDLE;
      end
      default: state_d = AIAC_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state_q <= AIAC_IDLE;
      cnt_q <= 24'h00_0000;
      endless_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (trig_take) begin
        cnt_q <= 24'h00_0000;
        endless_q <= burst_len == 24'h00_0000;
      end else if (samp_take && busy) begin
        cnt_q <= cnt_q + 24'h00_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel sequencer: one captured set drains one word per cycle
  logic [7:0][15:0] set_q;
  logic [7:0] pend_q;
  logic first_q;
  logic eob_set_q;
  logic adc_conv_q;

  wire [2:0] cur_idx = lowest_idx(pend_q);
  wire [7:0] cur_bit = pend_q & (~pend_q + 8'h01);
  wire [7:0] pend_rest = pend_q & ~cur_bit;
  wire seq_busy = pend_q != 8'h00;
  wire fifo_in_ready;
  wire fifo_push = seq_busy && buf_en;
  wire seq_step = seq_busy && (!buf_en || fifo_in_ready);
  wire samp_lost = samp_take && seq_busy && buf_en;

  aiac_entry_t push_entry;
  assign push_entry.data = set_q[cur_idx];
  assign push_entry.tag = first_q;
  assign push_entry.eob = eob_set_q && pend_rest == 8'h00;

  // a full FIFO stalls the sequencer; a sample clock that finds it still holding a set, stalled or draining, is lost
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pend_q <= 8'h00;
      first_q <= 1'b0;
      eob_set_q <= 1'b0;
      set_q <= '0;
      adc_conv_q <= 1'b0;
    end else begin
      adc_conv_q <= samp_take;
      if (samp_take && !seq_busy) begin
        set_q <= ADC_SAMPLES.value;
        pend_q <= buf_en ? chan_en : 8'h00;
        first_q <= 1'b1;
        eob_set_q <= last_set;
      end else if (!buf_en) begin
        pend_q <= 8'h00;
      end else if (seq_step) begin
        pend_q <= pend_rest;
        first_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input FIFO
  wire fifo_out_valid;
  aiac_entry_t fifo_out;
  wire fifo_pop = rd_fifo && fifo_out_valid;

  aiac_fifo #(
    .WIDTH($bits(aiac_entry_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLOCK),
    .rst(RESET),
    .flush(clr_q),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(push_entry),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // host registers
  wire ovf_set = samp_lost;
  wire unf_set = rd_fifo && !fifo_out_valid;
  wire ovf_wclr = wr_ctrl && !HOST_REQ.wdata[`AIAC_B_OVERFLOW];
  wire unf_wclr = wr_ctrl && !HOST_REQ.wdata[`AIAC_B_UNDERFLOW];
  wire flag_clr = clr_q || (wr_ctrl && HOST_REQ.wdata[`AIAC_B_BUF_CLR]);

  // pulse bits and flags live outside ctrl_q; pulse bits read as zero, busy and flags read as their own state
  wire [31:0] ctrl_wmask = ~((32'h1 << `AIAC_B_SW_CLK) | (32'h1 << `AIAC_B_SW_TRIG)
    | (32'h1 << `AIAC_B_BUF_CLR) | (32'h1 << `AIAC_B_BURST_BUSY)
    | (32'h1 << `AIAC_B_OVERFLOW) | (32'h1 << `AIAC_B_UNDERFLOW));

  wire [31:0] ctrl_rd = ctrl_q
    | (32'(busy) << `AIAC_B_BURST_BUSY)
    | (32'(ovf_q) << `AIAC_B_OVERFLOW)
    | (32'(unf_q) << `AIAC_B_UNDERFLOW);

  wire [31:0] fifo_rd = {14'h0000, fifo_out};

  wire [31:0] rd_mux =
    (HOST_REQ.addr == `AIAC_OFS_CTRL) ? ctrl_rd :
    (HOST_REQ.addr == `AIAC_OFS_FIFO) ? fifo_rd :
    (HOST_REQ.addr == `AIAC_OFS_CFG) ? cfg_q : 32'h0000_0000;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ctrl_q <= `AIAC_CTRL_RST;
      cfg_q <= `AIAC_CFG_RST;
      sw_clk_q <= 1'b0;
      sw_trig_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= HOST_REQ.wdata & ctrl_wmask;
      if (wr_cfg) cfg_q <= HOST_REQ.wdata;
      sw_clk_q <= wr_ctrl && HOST_REQ.wdata[`AIAC_B_SW_CLK];
      sw_trig_q <= wr_ctrl && HOST_REQ.wdata[`AIAC_B_SW_TRIG];
      clr_q <= wr_ctrl && HOST_REQ.wdata[`AIAC_B_BUF_CLR];
    end
  end

  // new events win over any clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_set || (ovf_q && !ovf_wclr && !flag_clr);
      unf_q <= unf_set || (unf_q && !unf_wclr && !flag_clr);
    end
  end

  // an empty read returns whatever sits at the read slot
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rd_data_q <= 32'h0000_0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= HOST_REQ.rd;
      if (HOST_REQ.rd) rd_data_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sync pin drivers
  logic [3:0] clk_pc_q;
  logic [3:0] trg_pc_q;
  logic clk_out_q;
  logic trg_out_q;
  logic trig_out_q;

  wire [3:0] clk_pc_d = pulse_next(clk_pc_q, clk_init && gen_clk);
  wire [3:0] trg_pc_d = pulse_next(trg_pc_q, trig_init && (gen_trig || OUT_TRIG_IN));

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      clk_pc_q <= 4'h0;
      trg_pc_q <= 4'h0;
      clk_out_q <= 1'b1;
      trg_out_q <= 1'b1;
      trig_out_q <= 1'b0;
    end else begin
      clk_pc_q <= clk_pc_d;
      trg_pc_q <= trg_pc_d;
      clk_out_q <= clk_pc_d == 4'h0;
      trg_out_q <= trg_pc_d == 4'h0;
      trig_out_q <= trg_fall;
    end
  end

  assign CLK_PIN_OUT = clk_out_q;
  assign CLK_PIN_OE = clk_init;
  assign TRIG_PIN_OUT = trg_out_q;
  assign TRIG_PIN_OE = trig_init;
  assign TRIG_TO_OUTPUT = trig_out_q;
  assign ADC_CONVERT = adc_conv_q;
  assign RD_DATA = rd_data_q;
  assign RD_VALID = rd_valid_q;

endmodule : aiac_top
`default_nettype wire

// file: aiac_consts.svh
`ifndef AIAC_CONSTS_SVH
`define AIAC_CONSTS_SVH

// register byte offsets
`define AIAC_OFS_CTRL 8'h00
`define AIAC_OFS_FIFO 8'h18
`define AIAC_OFS_CFG 8'h24

// control word bit positions
`define AIAC_B_SW_CLK 7
`define AIAC_B_BURST_EN 9
`define AIAC_B_BURST_BUSY 10
`define AIAC_B_SW_TRIG 11
`define AIAC_B_BUF_EN 12
`define AIAC_B_BUF_CLR 13
`define AIAC_B_OVERFLOW 15
`define AIAC_B_TRIG_INIT 21
`define AIAC_B_UNDERFLOW 23
`define AIAC_B_CLK_INIT 24
`define AIAC_B_RATE_A_EN 26
`define AIAC_B_RATE_B_EN 27

// configuration word fields
`define AIAC_CFG_LEN_MSB 23
`define AIAC_CFG_ENA_LSB 24

// reset values
`define AIAC_CTRL_RST 32'h0000_0000
`define AIAC_CFG_RST 32'hff00_0400

// sizes
`define AIAC_CHANNELS 8
`define AIAC_FIFO_DEPTH 262144

// timing
`define AIAC_CLK_PERIOD_NS 8
`define AIAC_PIN_PULSE_NS 100
`define AIAC_PIN_PULSE_CYC ((`AIAC_PIN_PULSE_NS + `AIAC_CLK_PERIOD_NS - 1) / `AIAC_CLK_PERIOD_NS)

`endif

// file: aiac_pkg.sv
`default_nettype none
package aiac_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } aiac_req_t;

  typedef struct packed {
    logic eob;
    logic tag;
    logic [15:0] data;
  } aiac_entry_t;

  typedef struct packed {
    logic [7:0][15:0] value;
  } aiac_adc_t;

  typedef enum logic [0:0] {
    AIAC_IDLE,
    AIAC_BURST
  } aiac_burst_t;

endpackage : aiac_pkg
`default_nettype wire

// file: aiac_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "aiac_consts.svh"
module aiac_assertions #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire aiac_pkg::aiac_req_t HOST_REQ,
  input wire logic [31:0] RD_DATA,
  input wire logic RD_VALID,
  input wire logic ADC_CONVERT,
  input wire logic TRIG_TO_OUTPUT,
  input wire logic OUT_TRIG_IN,
  input wire logic CLK_PIN_IN,
  input wire logic CLK_PIN_OUT,
  input wire logic CLK_PIN_OE,
  input wire logic TRIG_PIN_IN,
  input wire logic TRIG_PIN_OUT,
  input wire logic TRIG_PIN_OE
);
  import aiac_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // burst enable is not on a port, so track it from bus writes
  logic burst_q;
  wire logic ctrl_wr = HOST_REQ.wr && HOST_REQ.addr == `AIAC_OFS_CTRL;
  always_ff @(posedge CLOCK) begin
    if (RESET) burst_q <= 1'b0;
    else if (ctrl_wr) burst_q <= HOST_REQ.wdata[`AIAC_B_BURST_EN];
  end
  sequence s_clk_low12;
    !CLK_PIN_OUT [*8] ##1 !CLK_PIN_OUT [*4];
  endsequence
  sequence s_trig_low12;
    !TRIG_PIN_OUT [*8] ##1 !TRIG_PIN_OUT [*4];
  endsequence
  property p_reset_target;
    $past(RESET) |-> !CLK_PIN_OE && !TRIG_PIN_OE && CLK_PIN_OUT && TRIG_PIN_OUT;
  endproperty
  a_reset_target: assert property (p_reset_target) else $error("pins not in target mode after reset");
  property p_rd_answer;
    HOST_REQ.rd |=> RD_VALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
  property p_word_format;
    RD_VALID && $past(HOST_REQ.addr) == `AIAC_OFS_FIFO |-> RD_DATA[31:18] == 14'h0;
  endproperty
  a_word_format: assert property (p_word_format) else $error("buffer word upper bits not zero");
  property p_clk_pulse;
    CLK_PIN_OE && $fell(CLK_PIN_OUT) |=> s_clk_low12;
  endproperty
  a_clk_pulse: assert property (p_clk_pulse) else $error("clock pin pulse too short");
  property p_trig_pulse;
    TRIG_PIN_OE && OUT_TRIG_IN |-> ##[1:2] !TRIG_PIN_OUT ##1 s_trig_low12;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger pin pulse missing");
  property p_sw_clk;
    ctrl_wr && HOST_REQ.wdata[`AIAC_B_SW_CLK] && !HOST_REQ.wdata[`AIAC_B_BURST_EN] |-> ##[1:3] ADC_CONVERT;
  endproperty
  a_sw_clk: assert property (p_sw_clk) else $error("software clock gave no conversion");
  property p_tgt_clk;
    !CLK_PIN_OE && !burst_q && $fell(CLK_PIN_IN) |-> ##[2:6] ADC_CONVERT;
  endproperty
  a_tgt_clk: assert property (p_tgt_clk) else $error("clock pin edge gave no conversion");
  property p_tgt_trig;
    !TRIG_PIN_OE && $fell(TRIG_PIN_IN) |-> ##[2:6] TRIG_TO_OUTPUT;
  endproperty
  a_tgt_trig: assert property (p_tgt_trig) else $error("trigger pin edge not forwarded");
  property p_pin_dir;
    ctrl_wr |=> CLK_PIN_OE == $past(HOST_REQ.wdata[24]) && TRIG_PIN_OE == $past(HOST_REQ.wdata[21]);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction differs from control word");
endmodule : aiac_assertions
bind aiac_top aiac_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.CLOCK(CLOCK), .RESET(RESET),
  .HOST_REQ(HOST_REQ), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .ADC_CONVERT(ADC_CONVERT),
  .TRIG_TO_OUTPUT(TRIG_TO_OUTPUT), .OUT_TRIG_IN(OUT_TRIG_IN), .CLK_PIN_IN(CLK_PIN_IN),
  .CLK_PIN_OUT(CLK_PIN_OUT), .CLK_PIN_OE(CLK_PIN_OE), .TRIG_PIN_IN(TRIG_PIN_IN),
  .TRIG_PIN_OUT(TRIG_PIN_OUT), .TRIG_PIN_OE(TRIG_PIN_OE));
`default_nettype wire

// file: aiac_peer_model.sv
`timescale 1ns/10ps
`default_nettype none
module aiac_peer_model (
  input wire logic clk,
  output var aiac_pkg::aiac_adc_t adc,
  output logic clk_drv_n,
  output logic trig_drv_n
);
  import aiac_pkg::*;
  initial begin
    clk_drv_n = 1'b1;
    trig_drv_n = 1'b1;
    for (int n = 0; n < 8; n++) adc.value[n] = 16'hA000 + 16'h0101 * 16'(n);
  end
  // peer pulls the shared line low; release lets the pull-up win
  task automatic pulse(input logic trig, input int len);
    @(negedge clk);
    if (trig) trig_drv_n = 1'b0;
    else clk_drv_n = 1'b0;
    repeat (len) @(negedge clk);
    {clk_drv_n, trig_drv_n} = 2'b11;
  endtask : pulse
endmodule : aiac_peer_model
`default_nettype wire

// file: aiac_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module aiac_top_tb;
  import aiac_pkg::*;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} aiac_row_t;
  logic clk = 1'b0, rst = 1'b1, ra = 1'b0, rb = 1'b0, ot = 1'b0;
  aiac_req_t req = '0;
  aiac_adc_t adc;
  logic [31:0] rd_data, d;
  logic rd_valid, clk_out, clk_oe, trig_out, trig_oe, clk_drv_n, trig_drv_n;
  int mismatches = 0, total_checks = 0;
  aiac_row_t rows [4] = '{'{8'h24, 1'b0, 32'h0, 32'hff00_0400}, '{8'h00, 1'b0, 32'h0, 32'h0000_0000},
    '{8'h40, 1'b1, 32'hffff_ffff, 32'h0000_0000}, '{8'h24, 1'b1, 32'h0300_0002, 32'h0300_0002}};
  wire logic clk_line = (clk_oe ? clk_out : 1'b1) & clk_drv_n;
  wire logic trig_line = (trig_oe ? trig_out : 1'b1) & trig_drv_n;
  always #4 clk = ~clk;
  aiac_top #(.FIFO_DEPTH(8)) DUT (.CLOCK(clk), .RESET(rst), .HOST_REQ(req), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .ADC_SAMPLES(adc), .ADC_CONVERT(), .RATE_A_TICK(ra), .RATE_B_TICK(rb),
    .OUT_TRIG_IN(ot), .TRIG_TO_OUTPUT(), .CLK_PIN_IN(clk_line), .CLK_PIN_OUT(clk_out),
    .CLK_PIN_OE(clk_oe), .TRIG_PIN_IN(trig_line), .TRIG_PIN_OUT(trig_out), .TRIG_PIN_OE(trig_oe));
  aiac_peer_model peer (.clk(clk), .adc(adc), .clk_drv_n(clk_drv_n), .trig_drv_n(trig_drv_n));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk);
    req = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(negedge clk);
    req = '0;
    v = (rd_valid === 1'b1) ? rd_data : 'x;
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rdchk
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic tick(input logic [2:0] s);
    @(negedge clk);
    {ra, rb, ot} = s;
    @(negedge clk);
    {ra, rb, ot} = 3'h0;
  endtask : tick
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////
  initial begin
    idle(3);
    rst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    wr(8'h00, 32'h0000_1080);
    idle(8);
    peer.pulse(1'b0, 13);
    idle(8);
    for (int i = 0; i < 4; i++) rdchk(8'h18, {15'h0, ~i[0], 16'hA000 + 16'h0101 * i[0]});
    // rate A must be ignored while the clock pin is an input
    wr(8'h00, 32'h0400_1000);
    tick(3'b100);
    idle(6);
    rd(8'h18, d);
    rdchk(8'h00, 32'h0480_1000);
    wr(8'h00, 32'h0000_0080);
    idle(6);
    rdchk(8'h00, 32'h0000_0000);
    rd(8'h18, d);
    rdchk(8'h00, 32'h0080_0000);
    wr(8'h24, 32'h0100_0002);
    wr(8'h00, 32'h0000_1200);
    wr(8'h00, 32'h0000_1A00);
    rdchk(8'h00, 32'h0000_1600);
    wr(8'h00, 32'h0000_1A80);
    idle(4);
    wr(8'h00, 32'h0000_1280);
    idle(4);
    rdchk(8'h00, 32'h0000_1200);
    for (int i = 0; i < 2; i++) rdchk(8'h18, {14'h0, i == 1, 1'b1, 16'hA000});
    wr(8'h00, 32'h0000_1280);
    idle(4);
    rd(8'h18, d);
    rdchk(8'h00, 32'h0080_1200);
    wr(8'h24, 32'h0100_0000);
    wr(8'h00, 32'h0000_1200);
    peer.pulse(1'b1, 13);
    idle(5);
    rdchk(8'h00, 32'h0000_1600);
    peer.pulse(1'b0, 13);
    idle(6);
    peer.pulse(1'b0, 40);
    idle(6);
    rdchk(8'h00, 32'h0000_1600);
    wr(8'h24, 32'h0100_0005);
    idle(2);
    rdchk(8'h00, 32'h0000_1200);
    rdchk(8'h18, 32'h0001_A000);
    wr(8'h00, 32'h0000_3000);
    idle(2);
    rd(8'h18, d);
    rdchk(8'h00, 32'h0080_1000);
    wr(8'h24, 32'h0100_0003);
    wr(8'h00, 32'h0D20_1200);
    tick(3'b010);
    idle(2);
    rdchk(8'h00, 32'h0D20_1600);
    repeat (3) begin
      tick(3'b101);
      idle(14);
    end
    rdchk(8'h00, 32'h0D20_1200);
    for (int i = 0; i < 3; i++) rdchk(8'h18, {14'h0, i == 2, 1'b1, 16'hA000});
    // two channels into eight words: the sixth clock finds the set still stalled
    wr(8'h24, 32'h0300_0000);
    wr(8'h00, 32'h0500_1000);
    repeat (6) begin
      tick(3'b100);
      idle(14);
    end
    rdchk(8'h00, 32'h0500_9000);
    wr(8'h00, 32'h0500_1000);
    idle(2);
    rdchk(8'h00, 32'h0500_1000);
    // target trigger mode ignores rate B even with bursting armed
    wr(8'h00, 32'h0D00_1200);
    tick(3'b010);
    idle(2);
    rdchk(8'h00, 32'h0D00_1200);
    // reset in mid-run drops the initiator role and empties the FIFO
    rst = 1'b1;
    idle(3);
    rst = 1'b0;
    chk({30'h0, clk_oe, trig_oe}, 32'h0000_0000);
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h24, 32'hff00_0400);
    rd(8'h18, d);
    rdchk(8'h00, 32'h0080_0000);
    tally_and_finish();
  end
  initial begin
    #100us;
    mismatches++;
    tally_and_finish();
  end
endmodule : aiac_top_tb
`default_nettype wire
